// [rtl/jls_pkg.sv]
/*
 Package for the multiframe clock, reset distribution and link test pattern block.
 Assumes a single device clock domain and an AXI4-Lite master with 32-bit data.
*/
package jls_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MASK = 8'h04;
   localparam logic [7:0] ADDR_INIT = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int CTRL_SUBCLASS_LSB = 0;
   localparam int CTRL_LANES_LSB = 2;
   localparam int CTRL_RES_LSB = 4;
   localparam int CTRL_TEST_LSB = 6;
   localparam int CTRL_SCR_BIT = 8;
   localparam int CTRL_FORCE_BIT = 9;
   localparam int CTRL_REL_LSB = 10;
   localparam int CTRL_TPCONST_BIT = 12;
   localparam int CTRL_JESDA_BIT = 13;
   localparam int SYNC_LOW_MIN = 4;
   localparam int CORRUPT_CYCLES = 6;
   localparam int PRBS_BITS = 120;
   typedef enum logic [1:0] {
      JLS_SC0 = 2'h0, JLS_SC1 = 2'h1, JLS_SC2 = 2'h2
   } jls_subclass_t;
   typedef enum logic [1:0] {
      JLS_TP_OFF = 2'h0, JLS_TP_D21 = 2'h1, JLS_TP_K28 = 2'h2, JLS_TP_RPAT = 2'h3
   } jls_test_t;
   typedef enum logic [1:0] {
      JLS_ST_CGS = 2'h0, JLS_ST_WAIT = 2'h1, JLS_ST_ILA = 2'h3
   } jls_link_t;
endpackage : jls_pkg

// [rtl/jls_core.sv]
/*
 Multiframe clock, SYNC~/SYSREF reset distribution, masks and link test patterns.
 Assumes sync_request and sysref inputs are already synchronous to clk_i.
*/
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module jls_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sync_request_n_i,
   input wire logic sysref_in_i,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic multiframe_boundary_o,
   output logic divider_reset_o,
   output logic aux_reset_o,
   output logic odd_even_select_o,
   output logic data_invalid_o,
   output logic ila_start_o,
   output logic [4:0] k_field_o,
   output logic [7:0] lane_octet_o,
   output logic lane_is_k_o,
   output logic scramble_enable_o
);
   logic [31:0] ctrl;
   logic [2:0] mask;
   logic [4:0] multiframe_count_init;
   logic [4:0] mf_count;
   logic [4:0] frame_octet;
   logic sync_prev;
   logic sysref_prev;
   logic [2:0] sync_low_cnt;
   logic first_seen;
   logic [2:0] corrupt_cnt;
   localparam int PRBS_W = 7;
   logic [1:0] rel_cnt;
   logic [PRBS_W-1:0] prbs;
   jls_pkg::jls_link_t link_state;

   wire [1:0] subclass = ctrl[jls_pkg::CTRL_SUBCLASS_LSB +: 2];
   wire [1:0] adcs_per_lane_sel = ctrl[jls_pkg::CTRL_LANES_LSB +: 2];
   wire [1:0] resolution_sel = ctrl[jls_pkg::CTRL_RES_LSB +: 2];
   wire [1:0] link_test_pattern_select = ctrl[jls_pkg::CTRL_TEST_LSB +: 2];
   wire scrambler_on = ctrl[jls_pkg::CTRL_SCR_BIT];
   wire force_multiframe_count = ctrl[jls_pkg::CTRL_FORCE_BIT];
   wire [1:0] alignment_release_delay = ctrl[jls_pkg::CTRL_REL_LSB +: 2];
   wire tp_constant = ctrl[jls_pkg::CTRL_TPCONST_BIT];
   wire jesd204a = ctrl[jls_pkg::CTRL_JESDA_BIT];
   wire mask_divider_and_aux_reset = mask[0];
   wire mask_phase_and_divider_reset = mask[1];
   wire mask_after_first_event = mask[2];

   // Frame octets and K from lanes and resolution: 2/4/8 ADCs per lane.
   function automatic logic [4:0] frame_octets(input logic [1:0] lanes, input logic [1:0] res);
      logic [4:0] base;
      base = (res == 2'h0) ? 5'h03 : 5'h04;
      case (lanes)
         2'h0: frame_octets = base;
         2'h1: frame_octets = (res == 2'h0) ? 5'h06 : ((res == 2'h1) ? 5'h07 : 5'h08);
         default: frame_octets = (res == 2'h0) ? 5'h0C : ((res == 2'h1) ? 5'h0E : 5'h10);
      endcase
   endfunction : frame_octets

   function automatic logic [4:0] k_frames(input logic [1:0] lanes, input logic [1:0] res);
      case (lanes)
         2'h0: k_frames = (res == 2'h0) ? 5'h06 : 5'h05;
         2'h1: k_frames = 5'h03;
         default: k_frames = 5'h02;
      endcase
   endfunction : k_frames

   wire [4:0] octets = frame_octets(adcs_per_lane_sel, resolution_sel);
   wire [4:0] k_size = k_frames(adcs_per_lane_sel, resolution_sel);

   // Events are caught on rising clock edges only; SYSREF is active high.
   wire sync_rise = sync_request_n_i & ~sync_prev;
   wire sysref_rise = sysref_in_i & ~sysref_prev;
   // Event source follows the subclass; JESD204A behaves as subclass zero.
   wire sc1 = (subclass == jls_pkg::JLS_SC1) & ~jesd204a;
   wire sc2 = (subclass == jls_pkg::JLS_SC2) & ~jesd204a;
   wire event_hit = sc1 ? sysref_rise : sync_rise;
   // Mask three behaves as mask two once the first event has passed.
   wire eff_mask2 = mask_phase_and_divider_reset | (mask_after_first_event & first_seen);
   // Masks one and two act on the event itself; mask three is armed by it, so only later events see mask three.
   wire phase_reset = event_hit & (sc1 | sc2) & ~eff_mask2;
   wire div_reset = event_hit & ~mask_divider_and_aux_reset & ~eff_mask2;
   wire aux_reset = event_hit & ~mask_divider_and_aux_reset;
   wire frame_last = (frame_octet == octets - 5'h01);
   wire mf_wrap = frame_last & (mf_count == k_size - 5'h01);
   wire [4:0] reload = force_multiframe_count ? multiframe_count_init : 5'h00;
   // The fourth low sample itself qualifies, so a release right after it is still caught.
   wire sync_low_ok = (sync_low_cnt >= 3'(jls_pkg::SYNC_LOW_MIN - 1)) & ~sync_request_n_i;
   wire prbs_fb = prbs[PRBS_W-1] ^ prbs[PRBS_W-2];

   // Bus handshakes.
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
   wire [7:0] waddr = s_axi_awaddr[7:0];
   wire [7:0] raddr = s_axi_araddr[7:0];
   wire w_ctrl = wr_go & (waddr == jls_pkg::ADDR_CTRL);
   wire w_mask = wr_go & (waddr == jls_pkg::ADDR_MASK);
   wire w_init = wr_go & (waddr == jls_pkg::ADDR_INIT);
   wire w_hit = w_ctrl | w_mask | w_init;
   wire r_hit = (raddr == jls_pkg::ADDR_CTRL) | (raddr == jls_pkg::ADDR_MASK) |
      (raddr == jls_pkg::ADDR_INIT) | (raddr == jls_pkg::ADDR_STATUS) |
      (raddr == jls_pkg::ADDR_COUNT);
   wire [31:0] status_word = {24'h00_0000, first_seen, 1'b0, link_state, 1'b0, corrupt_cnt};
   wire [31:0] rd_word =
      (raddr == jls_pkg::ADDR_CTRL) ? ctrl :
      (raddr == jls_pkg::ADDR_MASK) ? {29'h0000_0000, mask} :
      (raddr == jls_pkg::ADDR_INIT) ? {27'h000_0000, multiframe_count_init} :
      (raddr == jls_pkg::ADDR_STATUS) ? status_word :
      (raddr == jls_pkg::ADDR_COUNT) ? {27'h000_0000, mf_count} : 32'h0000_0000;

   // Test pattern output: selected patterns never pass the scrambler; only the constant pattern does.
   logic [7:0] next_octet;
   logic next_is_k;
   always_comb begin
      next_octet = 8'h00;
      next_is_k = 1'b0;
      case (link_test_pattern_select)
         jls_pkg::JLS_TP_D21: next_octet = 8'hB5;
         jls_pkg::JLS_TP_K28: begin
            next_octet = 8'hBC;
            next_is_k = 1'b1;
         end
         jls_pkg::JLS_TP_RPAT: next_octet = {1'b0, prbs};
         default: begin
            next_octet = 8'h00;
            next_is_k = (link_state != jls_pkg::JLS_ST_ILA) ? 1'b1 : 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= jls_pkg::CTRL_RESET;
         mask <= 3'h0;
         multiframe_count_init <= 5'h00;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         s_axi_arready <= rd_go;
         if (w_ctrl && s_axi_wstrb[0]) ctrl[7:0] <= s_axi_wdata[7:0];
         if (w_ctrl && s_axi_wstrb[1]) ctrl[15:8] <= s_axi_wdata[15:8];
         if (w_mask && s_axi_wstrb[0]) mask <= s_axi_wdata[2:0];
         if (w_init && s_axi_wstrb[0]) multiframe_count_init <= s_axi_wdata[4:0];
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? 2'h0 : 2'h2;
         end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= r_hit ? 2'h0 : 2'h2;
         end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_prev <= 1'b1;
         sysref_prev <= 1'b0;
         sync_low_cnt <= 3'h0;
         first_seen <= 1'b0;
         frame_octet <= 5'h00;
         mf_count <= 5'h00;
         corrupt_cnt <= 3'h0;
         odd_even_select_o <= 1'b0;
         prbs <= 7'h7F;
         link_state <= jls_pkg::JLS_ST_CGS;
         rel_cnt <= 2'h0;
         multiframe_boundary_o <= 1'b0;
         divider_reset_o <= 1'b0;
         aux_reset_o <= 1'b0;
         data_invalid_o <= 1'b0;
         ila_start_o <= 1'b0;
         k_field_o <= 5'h00;
         lane_octet_o <= 8'h00;
         lane_is_k_o <= 1'b0;
         scramble_enable_o <= 1'b0;
      end else begin
         sync_prev <= sync_request_n_i;
         sysref_prev <= sysref_in_i;
         if (!mask_after_first_event) first_seen <= 1'b0;
         else if (event_hit) first_seen <= 1'b1;
         // Octet and frame counters; no local multiframe clock in subclass zero.
         if (phase_reset) begin
            frame_octet <= 5'h00;
            mf_count <= reload;
         end else if (!(sc1 | sc2)) begin
            frame_octet <= 5'h00;
            mf_count <= 5'h00;
         end else if (frame_last) begin
            frame_octet <= 5'h00;
            mf_count <= (mf_count >= k_size - 5'h01) ? 5'h00 : mf_count + 5'h01;
         end else frame_octet <= frame_octet + 5'h01;
         multiframe_boundary_o <= (sc1 | sc2) & mf_wrap & ~phase_reset;
         divider_reset_o <= div_reset;
         aux_reset_o <= aux_reset;
         // The odd/even selector and pattern phase restart with the aux reset.
         odd_even_select_o <= aux_reset ? 1'b0 : ~odd_even_select_o;
         prbs <= aux_reset ? 7'h7F : {prbs[PRBS_W-2:0], prbs_fb};
         // Samples after a SYSREF device reset are flagged for six clocks.
         if (aux_reset && sc1) corrupt_cnt <= 3'(jls_pkg::CORRUPT_CYCLES);
         else if (corrupt_cnt != 3'h0) corrupt_cnt <= corrupt_cnt - 3'h1;
         data_invalid_o <= (aux_reset & sc1) | (corrupt_cnt > 3'h1);
         // Low time of SYNC~ counted to enter synchronization.
         if (sync_request_n_i) sync_low_cnt <= 3'h0;
         else if (!sync_low_ok) sync_low_cnt <= sync_low_cnt + 3'h1;
         ila_start_o <= 1'b0;
         case (link_state)
            jls_pkg::JLS_ST_CGS: if (sync_rise) begin
               link_state <= jls_pkg::JLS_ST_WAIT;
               rel_cnt <= alignment_release_delay;
            end
            jls_pkg::JLS_ST_WAIT: if (sync_low_ok) begin
               link_state <= jls_pkg::JLS_ST_CGS;
            end else if (mf_wrap) begin
               if (rel_cnt == 2'h0) begin
                  link_state <= jls_pkg::JLS_ST_ILA;
                  ila_start_o <= 1'b1;
               end else rel_cnt <= rel_cnt - 2'h1;
            end
            jls_pkg::JLS_ST_ILA: if (sync_low_ok) link_state <= jls_pkg::JLS_ST_CGS;
            default: link_state <= jls_pkg::JLS_ST_CGS;
         endcase
         k_field_o <= k_size - 5'h01;
         lane_octet_o <= next_octet;
         lane_is_k_o <= next_is_k;
         // Scrambling only for live data, or constant pattern to give PRBS-like data.
         scramble_enable_o <= scrambler_on & (link_state == jls_pkg::JLS_ST_ILA) &
            (link_test_pattern_select == jls_pkg::JLS_TP_OFF) | (scrambler_on & tp_constant &
            (link_test_pattern_select == jls_pkg::JLS_TP_OFF));
      end
   end
endmodule : jls_core

// [bench/jls_core_sva.sv]
/* Port-level checker for jls_core.
 Assumes it is bound onto jls_core, with one clock and a synchronous reset. */
`timescale 1ns/1ps
module jls_core_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sync_request_n_i,
   input wire logic sysref_in_i,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic multiframe_boundary_o,
   input wire logic divider_reset_o,
   input wire logic aux_reset_o,
   input wire logic odd_even_select_o,
   input wire logic data_invalid_o,
   input wire logic ila_start_o,
   input wire logic [4:0] k_field_o
);
   logic prev_sync;
   logic prev_sref;
   logic [3:0] ev_hist;
   logic [3:0] sr_hist;
   logic [3:0] inv_len;
   // Edge history spans four cycles so that any registered reset latency of up to four is covered.
   always_ff @(posedge clk_i) begin
      prev_sync <= sync_request_n_i;
      prev_sref <= sysref_in_i;
      ev_hist <= {ev_hist[2:0], (sync_request_n_i & ~prev_sync) | (sysref_in_i & ~prev_sref)};
      sr_hist <= {sr_hist[2:0], sysref_in_i & ~prev_sref};
      inv_len <= (data_invalid_o & ~rst_i) ? inv_len + 4'h1 : 4'h0;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_div_cause: assert property (divider_reset_o |-> |ev_hist)
      else $error("divider reset without a rising event");
   a_aux_cause: assert property (aux_reset_o |-> |ev_hist)
      else $error("aux reset without a rising event");
   a_div_pulse: assert property (divider_reset_o |=> !divider_reset_o)
      else $error("divider reset longer than one cycle");
   a_bnd_pulse: assert property (multiframe_boundary_o |=> !multiframe_boundary_o)
      else $error("boundary pulse too long");
   a_k_legal: assert property (!$past(rst_i) |-> k_field_o inside {5'h05, 5'h04, 5'h02, 5'h01})
      else $error("illegal K field");
   a_oe_toggle: assert property (!aux_reset_o && !$past(aux_reset_o) && !$past(rst_i, 2)
      |-> odd_even_select_o != $past(odd_even_select_o))
      else $error("odd even select did not toggle");
   a_inv_len: assert property (inv_len <= 4'h6)
      else $error("invalid window longer than six");
   a_inv_cause: assert property ($rose(data_invalid_o) |-> |sr_hist)
      else $error("invalid window without sysref");
   a_ila_bnd: assert property (ila_start_o |-> multiframe_boundary_o || $past(multiframe_boundary_o))
      else $error("ila start off boundary");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
endmodule : jls_core_sva

// [bench/jls_rx_model.sv]
/* Receiver and SYSREF source model driving the link control inputs.
 Assumes tasks are called just after a rising edge of clk_i. */
`timescale 1ns/1ps
module jls_rx_model (
   input wire logic clk_i,
   output logic sync_request_n_o,
   output logic sysref_o
);
   initial begin
      sync_request_n_o = 1'b1;
      sysref_o = 1'b0;
   end
   task automatic sync_req(input int low_cycles);
      sync_request_n_o <= 1'b0;
      repeat (low_cycles) @(posedge clk_i);
      sync_request_n_o <= 1'b1;
   endtask : sync_req
   // One-shot only, so the period rule never comes into play.
   task automatic sysref_shot();
      sysref_o <= 1'b1;
      @(posedge clk_i);
      sysref_o <= 1'b0;
   endtask : sysref_shot
endmodule : jls_rx_model

// [bench/tb_jls_core.sv]
/* Self-checking bench for jls_core.
 Assumes the rx model drives the link inputs and the bench is AXI4-Lite master. */
`timescale 1ns/1ps
module tb_jls_core;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q;
   logic sync_request_n_i, sysref_in_i, multiframe_boundary_o, divider_reset_o, aux_reset_o;
   logic odd_even_select_o, data_invalid_o, ila_start_o, lane_is_k_o, scramble_enable_o;
   logic [4:0] k_field_o;
   logic [7:0] lane_octet_o;
   logic [31:0] seed = 32'h23;
   int error_cnt = 0, num_checks = 0, n_div = 0, n_aux = 0, n_bnd = 0;
   always #5 clk_i = ~clk_i;
   jls_rx_model rx (.clk_i, .sync_request_n_o(sync_request_n_i), .sysref_o(sysref_in_i));
   jls_core dut (.clk_i, .rst_i, .sync_request_n_i, .sysref_in_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .multiframe_boundary_o, .divider_reset_o,
      .aux_reset_o, .odd_even_select_o, .data_invalid_o, .ila_start_o, .k_field_o, .lane_octet_o,
      .lane_is_k_o, .scramble_enable_o);
   always @(posedge clk_i) begin
      if (divider_reset_o === 1'b1) n_div++;
      if (aux_reset_o === 1'b1) n_aux++;
      if (multiframe_boundary_o === 1'b1) n_bnd++;
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] exp_k(input int l, input int s);
      if (l == 0) return (s == 0) ? 32'h5 : 32'h4;
      return (l == 1) ? 32'h2 : 32'h1;
   endfunction : exp_k
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      bresp_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic fire_sysref();
      n_aux = 0;
      n_div = 0;
      rx.sysref_shot();
      repeat (8) @(posedge clk_i);
   endtask : fire_sysref
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial begin
      #400us;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int rel;
      int nb;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(jls_pkg::ADDR_CTRL, d, r);
      check("ctrl reset", d, jls_pkg::CTRL_RESET);
      rd(8'h20, d, r);
      check("unmapped rdata", d, 32'h0);
      check("unmapped rresp", {30'h0, r}, 32'h2);
      wr(8'h20, 32'hFFFF_FFFF);
      check("unmapped bresp", {30'h0, bresp_q}, 32'h2);
      for (int l = 0; l < 3; l++) begin
         for (int s = 0; s < 3; s++) begin
            wr(jls_pkg::ADDR_CTRL, 32'((l << jls_pkg::CTRL_LANES_LSB) | (s << jls_pkg::CTRL_RES_LSB)));
            repeat (2) @(posedge clk_i);
            check("k field", {27'h0, k_field_o}, exp_k(l, s));
         end
      end
      for (int t = 1; t < 4; t++) begin
         wr(jls_pkg::ADDR_CTRL, 32'((t << jls_pkg::CTRL_TEST_LSB) | (1 << jls_pkg::CTRL_SCR_BIT)));
         repeat (3) @(posedge clk_i);
         check("test scramble", {31'h0, scramble_enable_o}, 32'h0);
         if (t < 3) check("test octet", {23'h0, lane_is_k_o, lane_octet_o}, (t == 1) ? 32'h0B5 : 32'h1BC);
      end
      wr(jls_pkg::ADDR_CTRL, 32'((1 << jls_pkg::CTRL_SCR_BIT) | (1 << jls_pkg::CTRL_TPCONST_BIT)));
      repeat (3) @(posedge clk_i);
      check("const scramble", {31'h0, scramble_enable_o}, 32'h1);
      $display("test regs and patterns done");
      for (int i = 0; i < 4; i++) begin
         wr(jls_pkg::ADDR_CTRL, 32'(((i % 3) << jls_pkg::CTRL_SUBCLASS_LSB) | ((i / 3) << jls_pkg::CTRL_JESDA_BIT)));
         n_bnd = 0;
         if (i == 1) fire_sysref();
         else fire_sysref_skip: begin n_aux = 0; n_div = 0; end
         rx.sync_req(4);
         repeat (60) @(posedge clk_i);
         check("aux count", 32'(n_aux), 32'h1);
         check("div count", 32'(n_div), 32'h1);
         check("boundary seen", 32'(n_bnd != 0), 32'(i == 1 || i == 2));
      end
      $display("test subclass done");
      // Masks are exercised with SYSREF, so the link must be in subclass one here.
      wr(jls_pkg::ADDR_CTRL, 32'h1);
      for (int m = 0; m < 4; m++) begin
         wr(jls_pkg::ADDR_MASK, 32'((m == 3) ? 4 : m));
         fire_sysref();
         check("mask aux", 32'(n_aux), 32'(m != 1));
         if (m != 1) check("mask div", 32'(n_div), 32'(m == 0 || m == 3));
      end
      fire_sysref();
      check("mask later div", 32'(n_div), 32'h0);
      $display("test masks done");
      for (int j = 0; j < 3; j++) begin
         rel = int'(rnd() % 4);
         wr(jls_pkg::ADDR_CTRL, 32'(1 | (rel << jls_pkg::CTRL_REL_LSB)));
         rx.sync_req(int'(4 + rnd() % 4));
         // The rising edge is seen one clock later, so earlier boundaries do not count.
         repeat (2) @(posedge clk_i);
         nb = 0;
         for (int c = 0; c < 400 && ila_start_o !== 1'b1; c++) begin
            @(posedge clk_i);
            if (multiframe_boundary_o === 1'b1) nb++;
         end
         check("ila boundaries", 32'(nb), 32'(rel + 1));
      end
      $display("test ila done");
      report_and_stop();
   end
endmodule : tb_jls_core
bind jls_core jls_core_sva chk (.clk_i, .rst_i, .sync_request_n_i, .sysref_in_i, .s_axi_bvalid,
   .s_axi_bready, .multiframe_boundary_o, .divider_reset_o, .aux_reset_o, .odd_even_select_o,
   .data_invalid_o, .ila_start_o, .k_field_o);
